// *** nid_node_phy_regs.sv ***
`timescale 1ns/10ps
module nid_node_phy_regs
    import nid_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic bus_reset_pulse,
    input wire logic self_id_done_pulse,
    input wire logic [5:0] phy_node_number,
    input wire logic phy_is_root,
    input wire logic phy_cable_power_ok,
    output nid_phy_req_t phy_req,
    output logic phy_req_valid,
    input wire logic phy_req_ready,
    input wire nid_reg_xfer_t phy_status,
    input wire logic phy_status_valid,
    output logic irq
);
    logic node_valid_flag;
    logic root_flag;
    logic cable_power_ok;
    logic [9:0] bus_number_field;
    logic [5:0] physical_node_number;
    logic read_complete_flag;
    logic [3:0] received_reg_address;
    logic [7:0] received_reg_contents;
    logic read_request_bit;
    logic write_request_bit;
    logic [3:0] target_reg_address;
    logic [7:0] write_byte;
    logic [NID_IRQ_BITS-1:0] int_status;
    logic [NID_IRQ_BITS-1:0] int_mask;

    // Bus access decode.
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire hit_node = wb_adr_i == NID_OFS_NODE_IDENTITY;
    wire hit_phy = wb_adr_i == NID_OFS_PHY_REG_ACCESS;
    wire hit_ists = wb_adr_i == NID_OFS_INT_STATUS;
    wire hit_imask = wb_adr_i == NID_OFS_INT_MASK;
    wire wr_node = bus_wr && hit_node;
    wire wr_phy = bus_wr && hit_phy;
    wire wr_ists = bus_wr && hit_ists && wb_sel_i[0];
    wire wr_imask = bus_wr && hit_imask && wb_sel_i[0];

    // A request can only start while none is pending; makes both bits exclusive.
    wire req_idle = !read_request_bit && !write_request_bit;
    wire set_rd = wr_phy && wb_sel_i[1] && wb_dat_i[15] && req_idle;
    wire set_wr = wr_phy && wb_sel_i[1] && wb_dat_i[14] && !wb_dat_i[15] && req_idle;
    wire req_sent = phy_req_valid && phy_req_ready;

    wire [31:0] node_word = {node_valid_flag, root_flag, 2'b00, cable_power_ok, 11'h000,
        bus_number_field, physical_node_number};
    wire [31:0] phy_word = {read_complete_flag, 3'b000, received_reg_address,
        received_reg_contents, read_request_bit, write_request_bit, 2'b00,
        target_reg_address, write_byte};
    wire [31:0] read_word = hit_node ? node_word :
        hit_phy ? phy_word :
        hit_ists ? {{(32-NID_IRQ_BITS){1'b0}}, int_status} :
        hit_imask ? {{(32-NID_IRQ_BITS){1'b0}}, int_mask} : NID_UNMAPPED_DATA;

    wire [NID_IRQ_BITS-1:0] events = {phy_status_valid, self_id_done_pulse, bus_reset_pulse};
    wire [NID_IRQ_BITS-1:0] next_int_status =
        (int_status & ~(wr_ists ? wb_dat_i[NID_IRQ_BITS-1:0] : '0)) | events;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? read_word : '0;
        end
    end

    // Node identity register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            node_valid_flag <= 1'b0;
            root_flag <= 1'b0;
            cable_power_ok <= 1'b0;
            bus_number_field <= NID_BUS_NUMBER_RESET;
            physical_node_number <= NID_NODE_NUMBER_RESET;
        end else begin
            cable_power_ok <= phy_cable_power_ok;
            if (bus_reset_pulse) begin
                node_valid_flag <= 1'b0;
                root_flag <= phy_is_root;
            end
            if (self_id_done_pulse) begin
                physical_node_number <= phy_node_number;
                node_valid_flag <= 1'b1;
            end
            if (wr_node && wb_sel_i[0]) begin
                bus_number_field[1:0] <= wb_dat_i[7:6];
            end
            if (wr_node && wb_sel_i[1]) begin
                bus_number_field[9:2] <= wb_dat_i[15:8];
            end
        end
    end

    // Physical-layer access register and request port.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            read_complete_flag <= 1'b0;
            received_reg_address <= '0;
            received_reg_contents <= '0;
            read_request_bit <= 1'b0;
            write_request_bit <= 1'b0;
            target_reg_address <= '0;
            write_byte <= '0;
            phy_req_valid <= 1'b0;
            phy_req <= '0;
        end else begin
            if (wr_phy && wb_sel_i[1]) begin
                target_reg_address <= wb_dat_i[11:8];
            end
            if (wr_phy && wb_sel_i[0]) begin
                write_byte <= wb_dat_i[7:0];
            end
            if (set_rd || set_wr) begin
                read_complete_flag <= 1'b0;
            end
            if (phy_status_valid) begin
                read_complete_flag <= 1'b1;
                received_reg_address <= phy_status.addr;
                received_reg_contents <= phy_status.data;
            end
            if (set_rd) begin
                read_request_bit <= 1'b1;
                phy_req_valid <= 1'b1;
                phy_req.kind <= NID_REQ_READ;
                phy_req.addr <= wb_sel_i[1] ? wb_dat_i[11:8] : target_reg_address;
                phy_req.data <= '0;
            end else if (set_wr) begin
                write_request_bit <= 1'b1;
                phy_req_valid <= 1'b1;
                phy_req.kind <= NID_REQ_WRITE;
                phy_req.addr <= wb_dat_i[11:8];
                phy_req.data <= wb_sel_i[0] ? wb_dat_i[7:0] : write_byte;
            end else if (req_sent) begin
                read_request_bit <= 1'b0;
                write_request_bit <= 1'b0;
                phy_req_valid <= 1'b0;
                phy_req.kind <= NID_REQ_IDLE;
            end
        end
    end

    // Sticky events, set wins over a write-one clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_status <= '0;
            int_mask <= '0;
            irq <= 1'b0;
        end else begin
            int_status <= next_int_status;
            if (wr_imask) begin
                int_mask <= wb_dat_i[NID_IRQ_BITS-1:0];
            end
            irq <= |(next_int_status & (wr_imask ? wb_dat_i[NID_IRQ_BITS-1:0] : int_mask));
        end
    end
endmodule // nid_node_phy_regs

// *** nid_node_phy_regs_chk.sv ***
`timescale 1ns/10ps
module nid_node_phy_regs_chk
    import nid_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic phy_cable_power_ok,
    input wire nid_phy_req_t phy_req,
    input wire logic phy_req_valid,
    input wire logic phy_req_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire rd_id = rd_ack && wb_adr_i == NID_OFS_NODE_IDENTITY;
    wire rd_ph = rd_ack && wb_adr_i == NID_OFS_PHY_REG_ACCESS;
    wire go = take && wb_we_i && wb_adr_i == NID_OFS_PHY_REG_ACCESS && wb_sel_i[1]
        && (wb_dat_i[15] ^ wb_dat_i[14]) && !phy_req_valid;
    ack_once_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    req_hold_a: assert property (phy_req_valid && !phy_req_ready |=> phy_req_valid && $stable(phy_req))
        else $error("request dropped early");
    req_drop_a: assert property (phy_req_valid && phy_req_ready |=> !phy_req_valid)
        else $error("request not released");
    req_addr_a: assert property (go |=> phy_req_valid && phy_req.addr == $past(wb_dat_i[11:8]))
        else $error("request address wrong");
    rd_data_a: assert property (phy_req_valid && phy_req.kind == NID_REQ_READ |-> phy_req.data == 8'h00)
        else $error("read carries data");
    rsvd_id_a: assert property (rd_id |-> wb_dat_o[29:28] == 2'h0 && wb_dat_o[26:16] == 11'h000)
        else $error("node id reserved set");
    rsvd_ph_a: assert property (rd_ph |-> wb_dat_o[30:28] == 3'h0 && wb_dat_o[13:12] == 2'h0)
        else $error("phy access reserved set");
    cable_pwr_a: assert property (rd_id |-> wb_dat_o[27] == $past(phy_cable_power_ok, 2))
        else $error("cable power bit wrong");
endmodule // nid_node_phy_regs_chk
bind nid_node_phy_regs nid_node_phy_regs_chk chk (.*);

// *** nid_node_phy_regs_tb_top.sv ***
`timescale 1ns/10ps
module nid_node_phy_regs_tb_top;
    import nid_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} nid_row_t;
    logic sys_clk = 0, rst = 1, cyc = 0, we = 0, brst = 0, sid = 0, root = 1, cpo = 1;
    logic ack, valid, ready, st_valid, irq;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdat, dat_o;
    logic [1:0] slow = 2'h0;
    nid_phy_req_t req;
    nid_reg_xfer_t st;
    int n_fail = 0, compares = 0;
    nid_row_t rows [4] = '{'{8'hE8, 32'hFFFF_0280, 32'h4000_0285},
        '{8'hEC, 32'h7000_3ABC, 32'h0000_0ABC}, '{8'h10, 32'hFFFF_FFFF, 32'h0},
        '{8'hF8, 32'h4, 32'h4}};
    always #25 sys_clk = ~sys_clk;
    nid_node_phy_regs uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .bus_reset_pulse(brst), .self_id_done_pulse(sid),
        .phy_node_number(6'h05), .phy_is_root(root), .phy_cable_power_ok(cpo),
        .phy_req(req), .phy_req_valid(valid), .phy_req_ready(ready), .phy_status(st),
        .phy_status_valid(st_valid), .irq(irq));
    nid_phy_model phy (.sys_clk(sys_clk), .rst(rst), .slow(slow), .phy_req(req),
        .phy_req_valid(valid), .phy_req_ready(ready), .phy_status(st),
        .phy_status_valid(st_valid));
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wb(0, NID_OFS_NODE_IDENTITY, 0);
        chk("id reset", rdat, 32'h0800_FFFF);
        wb(0, NID_OFS_PHY_REG_ACCESS, 0);
        chk("access reset", rdat, 32'h0);
        @(posedge sys_clk) sid <= 1'b1;
        @(posedge sys_clk) sid <= 1'b0;
        wb(0, NID_OFS_NODE_IDENTITY, 0);
        chk("self id", rdat, 32'h8800_FFC5);
        @(posedge sys_clk) brst <= 1'b1;
        @(posedge sys_clk) brst <= 1'b0;
        cpo <= 1'b0;
        wb(0, NID_OFS_NODE_IDENTITY, 0);
        chk("bus reset", rdat, 32'h4000_FFC5);
        foreach (rows[i]) begin
            wb(1, rows[i].a, rows[i].w);
            wb(0, rows[i].a, 0);
            chk("row", rdat, rows[i].e);
        end
        chk("irq masked", {31'h0, irq}, 32'h0);
        slow <= 2'h2;
        wb(1, NID_OFS_PHY_REG_ACCESS, 32'h0000_8300);
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge sys_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        wb(0, NID_OFS_PHY_REG_ACCESS, 0);
        chk("read done", rdat, 32'h833C_0300);
        wb(1, NID_OFS_INT_STATUS, 32'h7);
        @(posedge sys_clk);
        chk("irq clear", {31'h0, irq}, 32'h0);
        slow <= 2'h3;
        wb(1, NID_OFS_PHY_REG_ACCESS, 32'h0000_45A5);
        for (int i = 0; i < 20 && !(valid === 1'b1 && ready === 1'b1); i++) @(posedge sys_clk);
        chk("write req", 32'(req), 32'({NID_REQ_WRITE, 12'h5A5}));
        wb(0, NID_OFS_PHY_REG_ACCESS, 0);
        chk("write done", rdat, 32'h033C_05A5);
        report_and_stop();
    end
endmodule // nid_node_phy_regs_tb_top

// *** nid_phy_model.sv ***
`timescale 1ns/10ps
module nid_phy_model
    import nid_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] slow,
    input wire nid_phy_req_t phy_req,
    input wire logic phy_req_valid,
    output logic phy_req_ready,
    output nid_reg_xfer_t phy_status,
    output logic phy_status_valid
);
    logic [1:0] wait_cnt;
    nid_reg_xfer_t last;
    assign phy_req_ready = phy_req_valid && wait_cnt == slow;
    // Outside its pulse the status bus shows junk so stale contents never pass for data.
    assign phy_status = phy_status_valid ? last : ~last;
    always_ff @(posedge sys_clk) begin
        phy_status_valid <= 1'b0;
        wait_cnt <= phy_req_valid && !phy_req_ready ? wait_cnt + 2'h1 : 2'h0;
        if (rst) begin
            last <= '0;
        end else if (phy_req_ready && phy_req.kind == NID_REQ_READ) begin
            last <= {phy_req.addr, phy_req.addr, ~phy_req.addr};
            phy_status_valid <= 1'b1;
        end
    end
endmodule // nid_phy_model

// *** nid_pkg.sv ***
package nid_pkg;
    localparam logic [7:0] NID_OFS_NODE_IDENTITY = 8'hE8;
    localparam logic [7:0] NID_OFS_PHY_REG_ACCESS = 8'hEC;
    localparam logic [7:0] NID_OFS_INT_STATUS = 8'hF4;
    localparam logic [7:0] NID_OFS_INT_MASK = 8'hF8;
    localparam logic [9:0] NID_BUS_NUMBER_RESET = 10'h3FF;
    localparam logic [5:0] NID_NODE_NUMBER_RESET = 6'h3F;
    localparam int NID_IRQ_BITS = 3;
    localparam int NID_IRQ_BUS_RESET = 0;
    localparam int NID_IRQ_SELF_ID_DONE = 1;
    localparam int NID_IRQ_READ_COMPLETE = 2;
    localparam logic [31:0] NID_UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } nid_reg_xfer_t;

    typedef enum logic [1:0] {
        NID_REQ_IDLE = 2'b00,
        NID_REQ_READ = 2'b01,
        NID_REQ_WRITE = 2'b10
    } nid_req_kind_t;

    typedef struct packed {
        nid_req_kind_t kind;
        logic [3:0] addr;
        logic [7:0] data;
    } nid_phy_req_t;
endpackage
